/* include/sebs_pkg.sv */
package sebs_pkg;

   // ==========================================================================
   // clock and time base
   localparam int CLK_FREQ_HZ = 32'h0773_5940;
   localparam int MS_PER_S = 32'h0000_03e8;
   localparam int CLKS_PER_MS = CLK_FREQ_HZ / MS_PER_S;
   localparam real POWERUP_TIME_S = 1.5;
   localparam int POWERUP_MS = int'(POWERUP_TIME_S * MS_PER_S);

   // ==========================================================================
   // register map, word index = byte address / 4
   localparam logic [2:0] REG_STANDSTILL_SPEED = 3'h0;
   localparam logic [2:0] REG_STANDSTILL_DELAY = 3'h1;
   localparam logic [2:0] REG_RUNNING_WAIT = 3'h2;
   localparam logic [2:0] REG_RUNNING_SPEED = 3'h3;
   localparam logic [2:0] REG_RELEASE_DELAY = 3'h4;
   localparam logic [2:0] REG_STATUS = 3'h5;

   // status register field positions
   localparam int ST_BIT_READY = 0;
   localparam int ST_BIT_POWER = 1;
   localparam int ST_BIT_BRAKE = 2;
   localparam int ST_BIT_ALARM = 3;
   localparam int ST_BIT_REQUEST = 4;
   localparam int ST_STATE_LSB = 8;

   // ==========================================================================
   // setting limits and reset values
   localparam logic [15:0] SPEED_MAX = 16'h0bb8;
   localparam logic [15:0] STANDSTILL_DELAY_MAX = 16'h7530;
   localparam logic [15:0] RUNNING_WAIT_MAX = 16'h2710;
   localparam logic [15:0] RELEASE_DELAY_MAX = 16'h2710;
   localparam logic [15:0] STANDSTILL_SPEED_RST = 16'h0005;
   localparam logic [15:0] STANDSTILL_DELAY_RST = 16'h012c;
   localparam logic [15:0] RUNNING_WAIT_RST = 16'h01f4;
   localparam logic [15:0] RUNNING_SPEED_RST = 16'h0064;
   localparam logic [15:0] RELEASE_DELAY_RST = 16'h012c;
   localparam logic [15:0] MS_ELAPSED_MAX = 16'hffff;

   // ==========================================================================
   // types
   typedef enum logic [2:0] {
      ST_POWERUP = 3'b000,
      ST_IDLE = 3'b001,
      ST_ENABLE = 3'b010,
      ST_RUN = 3'b011,
      ST_HOLD = 3'b100,
      ST_COAST = 3'b101
   } sebs_state_t;

   typedef struct packed {
      logic [15:0] standstill_speed_threshold;
      logic [15:0] standstill_brake_delay;
      logic [15:0] running_brake_wait_time;
      logic [15:0] running_brake_speed;
      logic [15:0] brake_release_delay;
   } sebs_cfg_t;

endpackage

/* rtl/sebs_sync3.sv */
`timescale 1ns/100ps
module sebs_sync3 (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic level_out
);

   logic stage1;
   logic stage2;
   logic stage3;

   // ==========================================================================
   // three-stage capture, output moves only when stages two and three agree
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         level_out <= 1'b0;
      end else if (stage2 == stage3) begin
         level_out <= stage3;
      end
   end

endmodule

/* rtl/sebs_ms_tick.sv */
`timescale 1ns/100ps
module sebs_ms_tick #(
   parameter int CLKS_PER_TICK = sebs_pkg::CLKS_PER_MS
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic restart,
   output logic tick
);

   localparam int CW = $clog2(CLKS_PER_TICK + 1);
   localparam logic [CW-1:0] LAST = CW'(CLKS_PER_TICK - 1);

   logic [CW-1:0] count;

   // ==========================================================================
   // divider, restart realigns the tick phase to the caller's event
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
      end else if (restart || count == LAST) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tick <= 1'b0;
      end else begin
         tick <= !restart && count == LAST;
      end
   end

endmodule

/* rtl/sebs_top.sv */
`timescale 1ns/100ps
module sebs_top #(
   parameter int CLKS_PER_MS = sebs_pkg::CLKS_PER_MS,
   parameter int POWERUP_MS = sebs_pkg::POWERUP_MS
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic servo_on_request,
   input wire logic alarm_in,
   input wire logic [15:0] motor_speed_rpm,
   output logic servo_ready_flag,
   output logic motor_power_on,
   output logic holding_brake_release
);

   sebs_pkg::sebs_state_t state;
   sebs_pkg::sebs_state_t next_state;
   sebs_pkg::sebs_cfg_t cfg;
   logic request_s;
   logic alarm_s;
   logic ms_tick;
   logic state_change;
   logic [15:0] ms_elapsed;
   logic bus_ack;
   logic [2:0] reg_idx;
   logic wr_take;
   logic low_speed;

   // ==========================================================================
   // pin inputs
   sebs_sync3 u_sync_request (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_in(servo_on_request),
      .level_out(request_s)
   );

   sebs_sync3 u_sync_alarm (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_in(alarm_in),
      .level_out(alarm_s)
   );

   // ==========================================================================
   // millisecond time base
   assign state_change = next_state != state;

   sebs_ms_tick #(
      .CLKS_PER_TICK(CLKS_PER_MS)
   ) u_ms_tick (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .restart(state_change),
      .tick(ms_tick)
   );

   // saturates so a long stay in one state never wraps into a false timeout
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ms_elapsed <= '0;
      end else if (state_change) begin
         ms_elapsed <= '0;
      end else if (ms_tick && ms_elapsed != sebs_pkg::MS_ELAPSED_MAX) begin
         ms_elapsed <= ms_elapsed + 16'h0001;
      end
   end

   // ==========================================================================
   // sequencer
   assign low_speed = motor_speed_rpm < cfg.standstill_speed_threshold;

   always_comb begin
      next_state = state;
      unique case (state)
         sebs_pkg::ST_POWERUP: begin
            if (ms_elapsed >= 16'(POWERUP_MS)) begin
               next_state = sebs_pkg::ST_IDLE;
            end
         end
         sebs_pkg::ST_IDLE: begin
            if (request_s && !alarm_s) begin
               next_state = sebs_pkg::ST_ENABLE;
            end
         end
         sebs_pkg::ST_ENABLE: begin
            if (alarm_s || !request_s) begin
               next_state = sebs_pkg::ST_IDLE;
            end else if (ms_elapsed >= cfg.brake_release_delay) begin
               next_state = sebs_pkg::ST_RUN;
            end
         end
         sebs_pkg::ST_RUN: begin
            if (alarm_s || !request_s) begin
               if (!low_speed) begin
                  next_state = sebs_pkg::ST_COAST;
               end else if (alarm_s) begin
                  next_state = sebs_pkg::ST_IDLE;
               end else begin
                  next_state = sebs_pkg::ST_HOLD;
               end
            end
         end
         sebs_pkg::ST_HOLD: begin
            if (alarm_s || ms_elapsed >= cfg.standstill_brake_delay) begin
               next_state = sebs_pkg::ST_IDLE;
            end
         end
         sebs_pkg::ST_COAST: begin
            if (ms_elapsed >= cfg.running_brake_wait_time ||
                motor_speed_rpm <= cfg.running_brake_speed) begin
               next_state = sebs_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = sebs_pkg::ST_POWERUP;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= sebs_pkg::ST_POWERUP;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================================
   // outputs, registered from the next state so they track state exactly
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         servo_ready_flag <= 1'b0;
      end else begin
         servo_ready_flag <= next_state != sebs_pkg::ST_POWERUP;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         motor_power_on <= 1'b0;
      end else begin
         motor_power_on <= next_state == sebs_pkg::ST_ENABLE ||
                           next_state == sebs_pkg::ST_RUN ||
                           next_state == sebs_pkg::ST_HOLD;
      end
   end

   // relay drive: high energises the coil and lifts the brake
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         holding_brake_release <= 1'b0;
      end else begin
         holding_brake_release <= next_state == sebs_pkg::ST_RUN ||
                                  next_state == sebs_pkg::ST_COAST;
      end
   end

   // ==========================================================================
   // register slave, one wait cycle per access
   function automatic logic [15:0] merge_clamp(
      input logic [15:0] old,
      input logic [31:0] wd,
      input logic [3:0] be,
      input logic [15:0] max
   );
      logic [15:0] v;
      v = old;
      if (be[0]) begin
         v[7:0] = wd[7:0];
      end
      if (be[1]) begin
         v[15:8] = wd[15:8];
      end
      merge_clamp = (v > max) ? max : v;
   endfunction

   assign reg_idx = avs_address[4:2];
   assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
   assign wr_take = avs_write && bus_ack;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bus_ack <= 1'b0;
      end else begin
         bus_ack <= (avs_read || avs_write) && !bus_ack;
      end
   end

   // out-of-range writes clamp to the limit rather than being dropped
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg.standstill_speed_threshold <= sebs_pkg::STANDSTILL_SPEED_RST;
         cfg.standstill_brake_delay <= sebs_pkg::STANDSTILL_DELAY_RST;
         cfg.running_brake_wait_time <= sebs_pkg::RUNNING_WAIT_RST;
         cfg.running_brake_speed <= sebs_pkg::RUNNING_SPEED_RST;
         cfg.brake_release_delay <= sebs_pkg::RELEASE_DELAY_RST;
      end else if (wr_take) begin
         unique case (reg_idx)
            sebs_pkg::REG_STANDSTILL_SPEED: begin
               cfg.standstill_speed_threshold <= merge_clamp(cfg.standstill_speed_threshold,
                  avs_writedata, avs_byteenable, sebs_pkg::SPEED_MAX);
            end
            sebs_pkg::REG_STANDSTILL_DELAY: begin
               cfg.standstill_brake_delay <= merge_clamp(cfg.standstill_brake_delay,
                  avs_writedata, avs_byteenable, sebs_pkg::STANDSTILL_DELAY_MAX);
            end
            sebs_pkg::REG_RUNNING_WAIT: begin
               cfg.running_brake_wait_time <= merge_clamp(cfg.running_brake_wait_time,
                  avs_writedata, avs_byteenable, sebs_pkg::RUNNING_WAIT_MAX);
            end
            sebs_pkg::REG_RUNNING_SPEED: begin
               cfg.running_brake_speed <= merge_clamp(cfg.running_brake_speed,
                  avs_writedata, avs_byteenable, sebs_pkg::SPEED_MAX);
            end
            sebs_pkg::REG_RELEASE_DELAY: begin
               cfg.brake_release_delay <= merge_clamp(cfg.brake_release_delay,
                  avs_writedata, avs_byteenable, sebs_pkg::RELEASE_DELAY_MAX);
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= '0;
      end else if (avs_read && !bus_ack) begin
         avs_readdata <= '0;
         unique case (reg_idx)
            sebs_pkg::REG_STANDSTILL_SPEED: begin
               avs_readdata[15:0] <= cfg.standstill_speed_threshold;
            end
            sebs_pkg::REG_STANDSTILL_DELAY: begin
               avs_readdata[15:0] <= cfg.standstill_brake_delay;
            end
            sebs_pkg::REG_RUNNING_WAIT: begin
               avs_readdata[15:0] <= cfg.running_brake_wait_time;
            end
            sebs_pkg::REG_RUNNING_SPEED: begin
               avs_readdata[15:0] <= cfg.running_brake_speed;
            end
            sebs_pkg::REG_RELEASE_DELAY: begin
               avs_readdata[15:0] <= cfg.brake_release_delay;
            end
            sebs_pkg::REG_STATUS: begin
               avs_readdata[sebs_pkg::ST_BIT_READY] <= servo_ready_flag;
               avs_readdata[sebs_pkg::ST_BIT_POWER] <= motor_power_on;
               avs_readdata[sebs_pkg::ST_BIT_BRAKE] <= holding_brake_release;
               avs_readdata[sebs_pkg::ST_BIT_ALARM] <= alarm_s;
               avs_readdata[sebs_pkg::ST_BIT_REQUEST] <= request_s;
               avs_readdata[sebs_pkg::ST_STATE_LSB +: 3] <= state;
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================================
   // checks
   AST_READY_ONLY_AFTER_POWERUP: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(servo_ready_flag) |-> $past(state) == sebs_pkg::ST_POWERUP &&
                                  $past(ms_elapsed) >= 16'(POWERUP_MS))
      else $error("ready rose before power-up delay");

   AST_NO_POWER_WHILE_UNREADY: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !servo_ready_flag |-> !motor_power_on && !holding_brake_release)
      else $error("motor powered while not ready");

   AST_ENABLE_POWERS_MOTOR: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      state == sebs_pkg::ST_IDLE && request_s && !alarm_s |=>
         motor_power_on && !holding_brake_release)
      else $error("enable request did not power the motor");

   AST_ALARM_CUTS_POWER: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      alarm_s |=> !motor_power_on)
      else $error("alarm left motor powered");

   AST_RUN_BRAKE_RELEASED: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      state == sebs_pkg::ST_RUN |-> holding_brake_release && motor_power_on)
      else $error("running without brake release");

   AST_STOP_SELECT: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      state == sebs_pkg::ST_RUN && !request_s && !alarm_s |=>
         state == ($past(low_speed) ? sebs_pkg::ST_HOLD : sebs_pkg::ST_COAST))
      else $error("wrong servo-off sequence chosen");

   AST_HOLD_ENERGISED: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      state == sebs_pkg::ST_HOLD |-> motor_power_on && !holding_brake_release)
      else $error("standstill stop not holding position");

   AST_HOLD_DELAY: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      state == sebs_pkg::ST_HOLD && !alarm_s && ms_elapsed < cfg.standstill_brake_delay
      |=> motor_power_on)
      else $error("power withdrawn before standstill delay");

   AST_COAST_OUTPUTS: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      state == sebs_pkg::ST_COAST |-> !motor_power_on && holding_brake_release)
      else $error("coasting stop drives wrong outputs");

   AST_COAST_END: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      state == sebs_pkg::ST_COAST && (motor_speed_rpm <= cfg.running_brake_speed ||
         ms_elapsed >= cfg.running_brake_wait_time) |=> !holding_brake_release)
      else $error("brake not engaged at running stop end");

   AST_RELEASE_AFTER_POWER: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(holding_brake_release) |-> $past(motor_power_on) &&
         $past(state) == sebs_pkg::ST_ENABLE &&
         $past(ms_elapsed) >= $past(cfg.brake_release_delay))
      else $error("brake released before release delay");

   AST_CFG_IN_RANGE: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cfg.standstill_speed_threshold <= sebs_pkg::SPEED_MAX &&
      cfg.running_brake_speed <= sebs_pkg::SPEED_MAX &&
      cfg.standstill_brake_delay <= sebs_pkg::STANDSTILL_DELAY_MAX &&
      cfg.running_brake_wait_time <= sebs_pkg::RUNNING_WAIT_MAX &&
      cfg.brake_release_delay <= sebs_pkg::RELEASE_DELAY_MAX)
      else $error("setting outside its range");

   AST_TIMER_RESTART: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      state != $past(state) |-> ms_elapsed == 16'h0000 && !ms_tick)
      else $error("timer not restarted on state change");

   AST_IGNORE_WHEN_UNREADY: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      state == sebs_pkg::ST_POWERUP |=>
         state inside {sebs_pkg::ST_POWERUP, sebs_pkg::ST_IDLE} && !holding_brake_release)
      else $error("request acted on before ready");

endmodule

/* testbench/sebs_host_model.sv */
`timescale 1ns/100ps
// ==========================================================================
// host controller and brake relay coil
module sebs_host_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic want_on,
   input wire logic force_early,
   input wire logic servo_ready_flag,
   input wire logic holding_brake_release,
   output logic servo_on_request,
   output logic brake_engaged
);
   // force_early lets a scenario break the wait-for-ready habit on purpose
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         servo_on_request <= 1'b0;
      end else begin
         servo_on_request <= want_on & (servo_ready_flag | force_early);
      end
   end
   // coil energised means the brake is lifted
   assign brake_engaged = ~holding_brake_release;
endmodule

/* testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
   // shortened time base keeps the run to a few hundred cycles
   localparam int CPM = 4;
   localparam int PUM = 3;
   localparam int DLY = 2;
   localparam int WAIT = 3;
   typedef struct {logic wr; logic [4:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] exp;} sebs_row_t;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic want_on = 1'b0;
   logic force_early = 1'b0;
   logic alarm_in = 1'b0;
   logic [15:0] motor_speed_rpm = 16'h0000;
   logic servo_on_request;
   logic servo_ready_flag;
   logic motor_power_on;
   logic holding_brake_release;
   logic brake_engaged;
   logic [31:0] rd;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;
   sebs_row_t rows [13] = '{
      '{1'b0, 5'h00, 4'hf, 32'h0000_0000, 32'h0000_0005},
      '{1'b0, 5'h04, 4'hf, 32'h0000_0000, 32'h0000_012c},
      '{1'b0, 5'h08, 4'hf, 32'h0000_0000, 32'h0000_01f4},
      '{1'b0, 5'h0c, 4'hf, 32'h0000_0000, 32'h0000_0064},
      '{1'b0, 5'h10, 4'hf, 32'h0000_0000, 32'h0000_012c},
      '{1'b0, 5'h18, 4'hf, 32'h0000_0000, 32'h0000_0000},
      '{1'b1, 5'h00, 4'hf, 32'hffff_ffff, 32'h0000_0bb8},
      '{1'b1, 5'h04, 4'hf, 32'hffff_ffff, 32'h0000_7530},
      '{1'b1, 5'h08, 4'hf, 32'hffff_ffff, 32'h0000_2710},
      '{1'b1, 5'h0c, 4'hf, 32'hffff_ffff, 32'h0000_0bb8},
      '{1'b1, 5'h10, 4'hf, 32'hffff_ffff, 32'h0000_2710},
      '{1'b1, 5'h00, 4'h1, 32'h0000_0005, 32'h0000_0b05},
      '{1'b1, 5'h1c, 4'hf, 32'h0000_1234, 32'h0000_0000}};

   always #4 clk_sys = ~clk_sys;

   sebs_top #(.CLKS_PER_MS(CPM), .POWERUP_MS(PUM)) u_sebs_top (.clk_sys(clk_sys), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .servo_on_request(servo_on_request), .alarm_in(alarm_in), .motor_speed_rpm(motor_speed_rpm),
      .servo_ready_flag(servo_ready_flag), .motor_power_on(motor_power_on),
      .holding_brake_release(holding_brake_release));
   sebs_host_model u_sebs_host_model (.clk_sys(clk_sys), .rst_n(rst_n), .want_on(want_on),
      .force_early(force_early), .servo_ready_flag(servo_ready_flag),
      .holding_brake_release(holding_brake_release), .servo_on_request(servo_on_request),
      .brake_engaged(brake_engaged));

   // ==========================================================================
   // comparisons and verdict
   task check_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask
   task check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task check_range(input string what, input int lo, input int hi, input int got);
      n_checks++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   // ==========================================================================
   // bus master; waitrequest and read data are taken at the rising edge, before the slave's updates land
   task bus_wait;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
   endtask
   task bus_write(input logic [4:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_byteenable <= be;
      avs_writedata <= d;
      avs_write <= 1'b1;
      bus_wait();
      avs_write <= 1'b0;
   endtask
   task bus_read(input logic [4:0] a);
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= 1'b1;
      bus_wait();
      avs_read <= 1'b0;
   endtask

   // ==========================================================================
   // sequencer helpers; sel 0 ready, 1 power, 2 brake release
   task wait_out(input int sel, input logic val, input int maxc, output int cnt);
      logic [2:0] outs;
      cnt = 0;
      outs = {holding_brake_release, motor_power_on, servo_ready_flag};
      while (outs[sel] !== val && cnt < maxc) begin
         @(negedge clk_sys);
         cnt++;
         outs = {holding_brake_release, motor_power_on, servo_ready_flag};
      end
   endtask
   task run_on;
      @(posedge clk_sys);
      want_on <= 1'b1;
      wait_out(1, 1'b1, 20, n);
      check_range("power latency", 3, 8, n);
      check_bit("brake at power on", 1'b0, holding_brake_release);
      wait_out(2, 1'b1, 40, n);
      check_range("release delay", DLY * CPM, DLY * CPM + 4, n);
      check_bit("power at release", 1'b1, motor_power_on);
      check_bit("relay coil lifts brake", 1'b0, brake_engaged);
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) bus_write(rows[i].a, rows[i].be, rows[i].d);
         bus_read(rows[i].a);
         check_word("register", rows[i].exp, rd);
      end
      // second reset with an early request that must be ignored
      @(posedge clk_sys);
      rst_n <= 1'b0;
      want_on <= 1'b1;
      force_early <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      wait_out(0, 1'b1, 40, n);
      check_range("ready delay", PUM * CPM, PUM * CPM + 4, n);
      check_bit("power before ready", 1'b0, motor_power_on);
      check_bit("brake before ready", 1'b0, holding_brake_release);
      @(posedge clk_sys);
      want_on <= 1'b0;
      force_early <= 1'b0;
      bus_read(5'h04);
      check_word("delay after reset", 32'h0000_012c, rd);
      bus_write(5'h04, 4'hf, 32'(DLY));
      bus_write(5'h08, 4'hf, 32'(WAIT));
      bus_write(5'h10, 4'hf, 32'(DLY));
      repeat (20) @(posedge clk_sys);
      // stop at standstill
      run_on();
      @(posedge clk_sys);
      want_on <= 1'b0;
      wait_out(2, 1'b0, 20, n);
      check_range("hold entry", 3, 8, n);
      check_bit("power while braking", 1'b1, motor_power_on);
      wait_out(1, 1'b0, 40, n);
      check_range("standstill delay", DLY * CPM, DLY * CPM + 4, n);
      // stop while running, wait time expires
      run_on();
      @(posedge clk_sys);
      motor_speed_rpm <= 16'h03e8;
      want_on <= 1'b0;
      wait_out(1, 1'b0, 20, n);
      check_range("coast entry", 3, 8, n);
      check_bit("brake while coasting", 1'b1, holding_brake_release);
      wait_out(2, 1'b0, 40, n);
      check_range("running wait", WAIT * CPM, WAIT * CPM + 4, n);
      // stop while running, speed falls first
      run_on();
      @(posedge clk_sys);
      want_on <= 1'b0;
      wait_out(1, 1'b0, 20, n);
      repeat (2) @(posedge clk_sys);
      motor_speed_rpm <= 16'h0032;
      wait_out(2, 1'b0, 10, n);
      check_range("brake at low speed", 1, 3, n);
      // alarm while running; speed drops with it so the stop goes straight to idle
      run_on();
      @(posedge clk_sys);
      motor_speed_rpm <= 16'h0000;
      alarm_in <= 1'b1;
      wait_out(1, 1'b0, 20, n);
      check_range("alarm power off", 3, 8, n);
      check_bit("brake on alarm", 1'b0, holding_brake_release);
      // request goes first, so the alarm clearing can never re-enable
      @(posedge clk_sys);
      want_on <= 1'b0;
      repeat (10) @(posedge clk_sys);
      bus_read(5'h14);
      check_word("status under alarm", 32'h0000_0109, rd);
      alarm_in <= 1'b0;
      repeat (10) @(posedge clk_sys);
      print_verdict();
   end
endmodule
